// >>> sct_pkg.sv
// Constants and types shared by the command timing block
// Functional notes
// - Any command spacing of rounded-up nanosecond counts is accepted without lockout.
// - Auto-precharge is held off until the row-active minimum since activate.
// - Loop disabled: write recovery waits the larger of four clocks or 15 ns.
// - Write recovery starts four clocks after write latency, two for fixed chop.
// - Loop disabled: read strobe reference is read plus additive latency minus one.
package sct_pkg;

  localparam int            NUM_BANKS  = 8;
  localparam int            BANK_W     = 3;
  localparam int            LAT_W      = 5;
  localparam int            DLY_DEPTH  = 64;
  localparam int            DLY_W      = 6;
  localparam int            CNT_W      = 8;
  localparam int            OUT_W      = 4;

  // Clock and time limits
  localparam int            CLK_PERIOD_PS      = 25000;
  localparam int            ROW_ACTIVE_MIN_PS  = 37500;
  localparam int            WR_RECOVERY_PS     = 15000;
  localparam int            DLL_OFF_WR_MIN_CK  = 4;

  function automatic int ceil_cycles(input int ps);
    int n;
    n = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (n < 1) ? 1 : n;
  endfunction

  // Rounded up since both are minimum limits
  localparam logic [CNT_W-1:0] ROW_ACTIVE_MIN_CYC =
    CNT_W'(ceil_cycles(ROW_ACTIVE_MIN_PS));
  localparam logic [CNT_W-1:0] WR_RECOVERY_CYC =
    CNT_W'(ceil_cycles(WR_RECOVERY_PS));
  localparam logic [CNT_W-1:0] DLL_OFF_WR_CYC =
    (WR_RECOVERY_CYC > CNT_W'(DLL_OFF_WR_MIN_CK)) ? WR_RECOVERY_CYC
                                                : CNT_W'(DLL_OFF_WR_MIN_CK);

  // Write recovery start and read reference offsets
  localparam logic [DLY_W-1:0] BURST_WR_OFFSET = 6'h04;
  localparam logic [DLY_W-1:0] CHOP_WR_OFFSET  = 6'h02;
  localparam logic [DLY_W-1:0] DLL_OFF_RD_ADJ  = 6'h01;

  // Command codes on the command pins
  localparam logic [2:0]    CMD_NOP = 3'h0;
  localparam logic [2:0]    CMD_ACT = 3'h1;
  localparam logic [2:0]    CMD_RD  = 3'h2;
  localparam logic [2:0]    CMD_RDA = 3'h3;
  localparam logic [2:0]    CMD_WR  = 3'h4;
  localparam logic [2:0]    CMD_WRA = 3'h5;
  localparam logic [2:0]    CMD_PRE = 3'h6;
  localparam logic [2:0]    CMD_REF = 3'h7;

  // Reset values
  localparam logic [CNT_W-1:0] CNT_RST = 8'h00;
  localparam logic [OUT_W-1:0] OUT_RST = 4'h0;

  typedef enum logic [1:0] {
    BK_IDLE,
    BK_OPEN,
    BK_AP_PEND
  } sct_bank_state_e;

endpackage

// >>> sct_bank_if.sv
// Per-bank strobes between the command decoder and a bank tracker
`timescale 1ns/100ps
interface sct_bank_if;
  logic activate;
  logic precharge_cmd;
  logic ap_read;
  logic ap_write;
  logic wr_issue;
  logic wr_rec_start;
  logic int_precharge;
  logic is_open;

  modport ctl  (output activate, precharge_cmd, ap_read, ap_write, wr_issue, wr_rec_start,
                input  int_precharge, is_open);
  modport bank (input  activate, precharge_cmd, ap_read, ap_write, wr_issue, wr_rec_start,
                output int_precharge, is_open);
endinterface

// >>> sct_bank.sv
// One bank: row-active holdoff and write recovery before auto-precharge
`timescale 1ns/100ps
module sct_bank (
  // Clock and reset
  input  wire logic   core_clk,
  input  wire logic   srst,
  // Mode
  input  wire logic   dll_disable,
  // Decoder side
  sct_bank_if.bank    bif
);
  import sct_pkg::*;

  sct_bank_state_e    state_q, state_d;
  logic [CNT_W-1:0]   ras_cnt_q, ras_cnt_d;
  logic [CNT_W-1:0]   wr_cnt_q, wr_cnt_d;
  logic [OUT_W-1:0]   wr_out_q, wr_out_d;
  logic               ap_wr_q, ap_wr_d;
  logic               pre_q, pre_d;
  logic [CNT_W-1:0]   wr_need;
  logic               fire;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    wr_need   = dll_disable ? DLL_OFF_WR_CYC : WR_RECOVERY_CYC;
    state_d   = state_q;
    ap_wr_d   = ap_wr_q;
    pre_d     = 1'b0;
    ras_cnt_d = (ras_cnt_q == {CNT_W{1'b1}}) ? ras_cnt_q : ras_cnt_q + 8'h01;
    wr_cnt_d  = (wr_cnt_q == {CNT_W{1'b1}}) ? wr_cnt_q : wr_cnt_q + 8'h01;
    wr_out_d  = wr_out_q;
    // Issue and start in one cycle cancel out
    if (bif.wr_issue && !bif.wr_rec_start) begin
      wr_out_d = wr_out_q + 4'h1;
    end else if (!bif.wr_issue && bif.wr_rec_start && wr_out_q != OUT_RST) begin
      wr_out_d = wr_out_q - 4'h1;
    end
    if (bif.wr_rec_start) begin
      wr_cnt_d = CNT_RST;
    end
    // Recovery counts from the last write still in flight to this bank
    fire = (ras_cnt_q >= ROW_ACTIVE_MIN_CYC) && (wr_out_q == OUT_RST) &&
           (!ap_wr_q || wr_cnt_q >= wr_need);
    unique case (state_q)
      BK_IDLE: begin
        if (bif.activate) begin
          state_d   = BK_OPEN;
          ras_cnt_d = CNT_RST;
        end
      end
      BK_OPEN: begin
        if (bif.precharge_cmd) begin
          state_d = BK_IDLE;
        end else if (bif.ap_read || bif.ap_write) begin
          state_d = BK_AP_PEND;
          ap_wr_d = bif.ap_write;
        end
      end
      BK_AP_PEND: begin
        if (fire) begin
          state_d = BK_IDLE;
          pre_d   = 1'b1;
          ap_wr_d = 1'b0;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_q   <= BK_IDLE;
      ras_cnt_q <= CNT_RST;
      wr_cnt_q  <= CNT_RST;
      wr_out_q  <= OUT_RST;
      ap_wr_q   <= 1'b0;
      pre_q     <= 1'b0;
    end else begin
      state_q   <= state_d;
      ras_cnt_q <= ras_cnt_d;
      wr_cnt_q  <= wr_cnt_d;
      wr_out_q  <= wr_out_d;
      ap_wr_q   <= ap_wr_d;
      pre_q     <= pre_d;
    end
  end

  assign bif.int_precharge = pre_q;
  assign bif.is_open       = (state_q != BK_IDLE);

endmodule

// >>> sct_timing.sv
// Command timing core: decode, latency delay lines, bank trackers
`timescale 1ns/100ps
module sct_timing (
  // Clock and reset
  input  wire logic                          core_clk,
  input  wire logic                          srst,
  // Command pins
  input  wire logic                          cmd_valid,
  input  wire logic [2:0]                    cmd_code,
  input  wire logic [sct_pkg::BANK_W-1:0]    cmd_bank,
  // Mode settings, same clock
  input  wire logic [sct_pkg::LAT_W-1:0]     read_latency,
  input  wire logic [sct_pkg::LAT_W-1:0]     additive_latency,
  input  wire logic [sct_pkg::LAT_W-1:0]     write_latency,
  input  wire logic                          four_beat_chop_fixed,
  input  wire logic                          dll_disable,
  // Status and events
  output logic [sct_pkg::NUM_BANKS-1:0]      int_precharge,
  output logic [sct_pkg::NUM_BANKS-1:0]      bank_open,
  output logic                               wr_recovery_start,
  output logic [sct_pkg::BANK_W-1:0]         wr_recovery_bank,
  output logic                               rd_strobe_ref,
  output logic                               lock_required
);
  import sct_pkg::*;

  localparam int SYNC_W = 1 + 3 + BANK_W;

  logic [SYNC_W-1:0]  sync1_q, sync1_d;
  logic [SYNC_W-1:0]  sync2_q, sync2_d;
  logic               c_valid;
  logic [2:0]         c_code;
  logic [BANK_W-1:0]  c_bank;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser

  always_comb begin
    sync1_d = {cmd_valid, cmd_code, cmd_bank};
    sync2_d = sync1_q;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
    end
  end

  assign c_valid = sync2_q[SYNC_W-1];
  assign c_code  = sync2_q[SYNC_W-2 -: 3];
  assign c_bank  = sync2_q[BANK_W-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // Latency delay lines

  // Fixed per-mode delay, so two writes never land in one slot while the mode holds
  logic [BANK_W:0]    wr_dly_q [DLY_DEPTH];
  logic [BANK_W:0]    wr_dly_d [DLY_DEPTH];
  logic               rd_dly_q [DLY_DEPTH];
  logic               rd_dly_d [DLY_DEPTH];
  logic [DLY_W-1:0]   wr_delay;
  logic [DLY_W-1:0]   rd_delay;
  logic [DLY_W-1:0]   wr_idx;
  logic [DLY_W-1:0]   rd_idx;
  logic               is_wr;
  logic               is_rd;
  logic               lock_d, lock_q;
  logic               wrs_d, wrs_q;
  logic [BANK_W-1:0]  wrb_d, wrb_q;
  logic               rdr_d, rdr_q;

  always_comb begin
    is_wr    = c_valid && (c_code == CMD_WR || c_code == CMD_WRA);
    is_rd    = c_valid && (c_code == CMD_RD || c_code == CMD_RDA);
    wr_delay = DLY_W'(write_latency) +
               (four_beat_chop_fixed ? CHOP_WR_OFFSET : BURST_WR_OFFSET);
    rd_delay = DLY_W'(read_latency) + DLY_W'(additive_latency) - DLL_OFF_RD_ADJ;
    wr_idx   = wr_delay - 6'h01;
    rd_idx   = (rd_delay > 6'h01) ? rd_delay - 6'h01 : 6'h00;
    for (int i = 0; i < DLY_DEPTH; i++) begin
      wr_dly_d[i] = (i == DLY_DEPTH - 1) ? '0 : wr_dly_q[(i + 1) % DLY_DEPTH];
      rd_dly_d[i] = (i == DLY_DEPTH - 1) ? 1'b0 : rd_dly_q[(i + 1) % DLY_DEPTH];
    end
    if (is_wr) begin
      wr_dly_d[wr_idx] = {1'b1, c_bank};
    end
    if (is_rd && dll_disable) begin
      rd_dly_d[rd_idx] = 1'b1;
    end
    // Flag only; the controller owns the locked-loop exit wait
    lock_d = is_rd;
    wrs_d  = wr_dly_q[0][BANK_W];
    wrb_d  = wr_dly_q[0][BANK_W-1:0];
    rdr_d  = rd_dly_q[0];
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      for (int i = 0; i < DLY_DEPTH; i++) begin
        wr_dly_q[i] <= '0;
        rd_dly_q[i] <= 1'b0;
      end
      lock_q <= 1'b0;
      wrs_q  <= 1'b0;
      wrb_q  <= '0;
      rdr_q  <= 1'b0;
    end else begin
      for (int i = 0; i < DLY_DEPTH; i++) begin
        wr_dly_q[i] <= wr_dly_d[i];
        rd_dly_q[i] <= rd_dly_d[i];
      end
      lock_q <= lock_d;
      wrs_q  <= wrs_d;
      wrb_q  <= wrb_d;
      rdr_q  <= rdr_d;
    end
  end

  assign wr_recovery_start = wrs_q;
  assign wr_recovery_bank  = wrb_q;
  assign rd_strobe_ref     = rdr_q;
  assign lock_required     = lock_q;

  ////////////////////////////////////////////////////////////////////////////
  // Bank trackers

  // No spacing checks: commands are taken every cycle as presented
  sct_bank_if bif [NUM_BANKS] ();

  for (genvar g = 0; g < NUM_BANKS; g++) begin : g_bank
    logic hit;
    assign hit                  = c_valid && (c_bank == BANK_W'(g));
    assign bif[g].activate      = hit && (c_code == CMD_ACT);
    assign bif[g].precharge_cmd = hit && (c_code == CMD_PRE);
    assign bif[g].ap_read       = hit && (c_code == CMD_RDA);
    assign bif[g].ap_write      = hit && (c_code == CMD_WRA);
    assign bif[g].wr_issue      = hit && (c_code == CMD_WR || c_code == CMD_WRA);
    assign bif[g].wr_rec_start  = wr_dly_q[0][BANK_W] &&
                                  (wr_dly_q[0][BANK_W-1:0] == BANK_W'(g));
    assign int_precharge[g]     = bif[g].int_precharge;
    assign bank_open[g]         = bif[g].is_open;

    sct_bank u_bank (
      .core_clk    (core_clk),
      .srst        (srst),
      .dll_disable (dll_disable),
      .bif         (bif[g])
    );
  end

endmodule

// >>> sct_timing_sva.sv
// Checker for the command timing block outputs
`timescale 1ns/100ps
module sct_timing_chk
  import sct_pkg::*;
(
  // Clock and reset
  input wire logic                       core_clk,
  input wire logic                       srst,
  // Command and mode inputs
  input wire logic                       cmd_valid,
  input wire logic [2:0]                 cmd_code,
  input wire logic [sct_pkg::LAT_W-1:0]  read_latency,
  input wire logic [sct_pkg::LAT_W-1:0]  additive_latency,
  input wire logic [sct_pkg::LAT_W-1:0]  write_latency,
  input wire logic                       four_beat_chop_fixed,
  input wire logic                       dll_disable,
  // Outputs watched
  input wire logic [sct_pkg::NUM_BANKS-1:0] int_precharge,
  input wire logic [sct_pkg::NUM_BANKS-1:0] bank_open,
  input wire logic                       wr_recovery_start,
  input wire logic                       rd_strobe_ref,
  input wire logic                       lock_required
);
  logic [63:0] wr_h_q, wr_h_d, rd_h_q, rd_h_d;
  logic [6:0]  wr_i, rd_i, lat_s;
  logic        is_wr, is_rd;
  ////////////////////////////////////////////////////////////////////////////
  // History of commands, cleared by reset so stale ones never match
  always_comb begin
    is_wr = cmd_valid && (cmd_code == CMD_WR || cmd_code == CMD_WRA);
    is_rd = cmd_valid && (cmd_code == CMD_RD || cmd_code == CMD_RDA);
    wr_h_d = srst ? 64'h0 : {wr_h_q[62:0], is_wr};
    rd_h_d = srst ? 64'h0 : {rd_h_q[62:0], is_rd};
    // Pin to pulse: two sync flops ahead of the line, one output flop after it
    wr_i = 7'(write_latency) + 7'h02 +
           7'(four_beat_chop_fixed ? CHOP_WR_OFFSET : BURST_WR_OFFSET);
    lat_s = 7'(read_latency) + 7'(additive_latency);
    rd_i = (lat_s > 7'h01) ? lat_s + 7'h01 : 7'h03;
  end
  always_ff @(posedge core_clk) begin
    wr_h_q <= wr_h_d;
    rd_h_q <= rd_h_d;
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  a_lock_after_rd: assert property (is_rd |-> ##3 lock_required)
    else $error("lock pulse missing after read");
  a_lock_cause: assert property (lock_required |-> $past(is_rd, 3))
    else $error("lock pulse without read");
  a_wrrec_cause: assert property (wr_recovery_start |-> wr_h_q[wr_i])
    else $error("write recovery start at wrong offset");
  a_rdref_cause: assert property (rd_strobe_ref |-> dll_disable && rd_h_q[rd_i])
    else $error("read reference at wrong offset");
  a_rdref_made: assert property (dll_disable && rd_h_q[rd_i] |-> rd_strobe_ref)
    else $error("read reference missing");
  // Two-cycle row-active minimum: bank seen open three samples before the pulse
  a_ap_holdoff: assert property ((int_precharge & ~($past(bank_open, 1)
    & $past(bank_open, 2) & $past(bank_open, 3))) == 8'h00)
    else $error("precharge before row active min");
  a_ap_closes: assert property ((int_precharge & bank_open) == 8'h00)
    else $error("bank open during internal precharge");
  a_reset_quiet: assert property (disable iff (1'b0) srst |=> !lock_required
    && int_precharge == 8'h00 && bank_open == 8'h00) else $error("outputs busy after reset");
  c_lock: cover property (lock_required);
  c_wrrec: cover property (wr_recovery_start);
  c_ap: cover property (|int_precharge);
endmodule
bind sct_timing sct_timing_chk u_chk (.*);

// >>> sct_host_model.sv
// Host controller model driving the command pins
`timescale 1ns/100ps
module sct_host_model
  import sct_pkg::*;
#(
  // Refresh interval, a maximum so rounded down
  parameter int REFI_CYC = 7800000 / CLK_PERIOD_PS
)
(
  // Clock
  input wire logic                      core_clk,
  // Command pins
  output logic                          cmd_valid,
  output logic [2:0]                    cmd_code,
  output logic [sct_pkg::BANK_W-1:0]    cmd_bank
);
  initial begin
    cmd_valid = 1'b0;
    cmd_code = CMD_NOP;
    cmd_bank = 3'h0;
  end
  // Driven after the falling edge so the rising edge sees it settled
  task automatic send(input logic [2:0] c, input logic [BANK_W-1:0] b);
    @(negedge core_clk);
    cmd_valid = 1'b1;
    cmd_code = c;
    cmd_bank = b;
  endtask
  // Released fields flip so a stale value never passes for a command
  task automatic release_pins();
    @(negedge core_clk);
    cmd_valid = 1'b0;
    cmd_code = ~cmd_code;
    cmd_bank = ~cmd_bank;
  endtask
  // Clock periods above this owe a precharge of every bank after refresh
  localparam int SLOW_CLK_PS = 40000;
  // Pins go idle after a refresh, so two refreshes never sit back to back
  task automatic refresh();
    send(CMD_REF, 3'h0);
    release_pins();
    if (CLK_PERIOD_PS > SLOW_CLK_PS) begin
      for (int b = 0; b < NUM_BANKS; b++) begin
        send(CMD_PRE, BANK_W'(b));
      end
      release_pins();
    end
  endtask
endmodule

// >>> tb_top.sv
// Self-checking bench for the command timing block
`timescale 1ns/100ps
module tb_top;
  import sct_pkg::*;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic cmd_valid, wr_st, rd_ref, lock;
  logic [2:0] cmd_code;
  logic [BANK_W-1:0] cmd_bank, wr_bank;
  logic [LAT_W-1:0] rl = 5'h05, al = 5'h00, wl = 5'h05;
  logic chop = 1'b0, dll = 1'b0;
  logic [NUM_BANKS-1:0] int_pre, open;
  int failures = 0;
  int total_checks = 0;
  always #12.5 core_clk = ~core_clk;
  sct_timing dut (.core_clk(core_clk), .srst(srst), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_bank(cmd_bank), .read_latency(rl), .additive_latency(al),
    .write_latency(wl), .four_beat_chop_fixed(chop), .dll_disable(dll),
    .int_precharge(int_pre), .bank_open(open), .wr_recovery_start(wr_st),
    .wr_recovery_bank(wr_bank), .rd_strobe_ref(rd_ref), .lock_required(lock));
  sct_host_model host (.core_clk(core_clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_bank(cmd_bank));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic pair(input logic [2:0] c, input logic [BANK_W-1:0] b);
    host.send(CMD_ACT, b);
    host.send(c, b);
    host.release_pins();
  endtask
  task automatic close(input logic [BANK_W-1:0] b);
    host.send(CMD_PRE, b);
    host.release_pins();
    cyc(6);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_lock();
    pair(CMD_RD, 3'h1);
    cyc(1);
    chk("lock_act", 32'(lock), 0);
    cyc(1);
    chk("lock_rd", 32'(lock), 1);
    cyc(1);
    chk("lock_len", 32'(lock), 0);
    close(3'h1);
    $display("t_lock done");
  endtask
  task automatic t_rdref();
    int d;
    dll = 1'b1;
    for (int k = 0; k < 2; k++) begin
      rl = k ? 5'h01 : 5'h05;
      al = k ? 5'h00 : 5'h02;
      d = (rl + al > 1) ? rl + al - 1 : 1;
      pair(CMD_RD, 3'h2);
      cyc(d + 1);
      chk("ref_early", 32'(rd_ref), 0);
      cyc(1);
      chk("ref_at", 32'(rd_ref), 1);
      close(3'h2);
    end
    dll = 1'b0;
    $display("t_rdref done");
  endtask
  task automatic t_wrst();
    int d;
    for (int k = 0; k < 2; k++) begin
      chop = k[0];
      d = wl + (k ? 2 : 4);
      pair(CMD_WR, 3'h3);
      cyc(d + 1);
      chk("wr_early", 32'(wr_st), 0);
      cyc(1);
      chk("wr_at", 32'(wr_st), 1);
      chk("wr_bank", 32'(wr_bank), 3);
      close(3'h3);
    end
    chop = 1'b0;
    $display("t_wrst done");
  endtask
  // Back-to-back activate and read with auto precharge
  task automatic t_walk();
    pair(CMD_RDA, 3'h0);
    cyc(3);
    chk("ap_hold", 32'(int_pre), 0);
    chk("open_hold", 32'(open[0]), 1);
    cyc(1);
    chk("ap_fire", 32'(int_pre), 1);
    chk("open_low", 32'(open[0]), 0);
    cyc(4);
    $display("t_walk done");
  endtask
  task automatic t_dllwr();
    int ts, tp;
    for (int k = 0; k < 2; k++) begin
      dll = k[0];
      ts = -1;
      tp = -1;
      pair(CMD_WRA, 3'h5);
      for (int i = 0; i < 60 && tp < 0; i++) begin
        if (wr_st === 1'b1) ts = i;
        if (int_pre[5] === 1'b1) tp = i;
        cyc(1);
      end
      chk("wra_gap", 32'(tp - ts >= (k ? 4 : 1)), 1);
      chk("wra_start", 32'(ts >= 0), 1);
      cyc(4);
    end
    dll = 1'b0;
    $display("t_dllwr done");
  endtask
  // Reset in mid-run with a bank open and the lock pulse of a read still pending
  task automatic t_reset();
    pair(CMD_RD, 3'h6);
    cyc(1);
    chk("rst_open_before", 32'(open[6]), 1);
    srst = 1'b1;
    cyc(3);
    srst = 1'b0;
    chk("rst_open", 32'(open), 0);
    chk("rst_pre", 32'(int_pre), 0);
    chk("rst_lock", 32'(lock), 0);
    cyc(4);
    chk("rst_lock_late", 32'(lock), 0);
    $display("t_reset done");
  endtask
  // Refresh leaves banks and status untouched
  task automatic t_ref();
    host.refresh();
    cyc(4);
    chk("ref_open", 32'(open), 0);
    chk("ref_lock", 32'(lock), 0);
    chk("ref_wr", 32'(wr_st), 0);
    $display("t_ref done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    cyc(10);
    srst = 1'b0;
    t_lock();
    t_rdref();
    t_wrst();
    t_walk();
    t_dllwr();
    t_reset();
    t_ref();
    report_and_stop();
  end
  // Whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge core_clk);
    failures++;
    report_and_stop();
  end
endmodule
